/* File: design/fecrp_pkg.sv */
package fecrp_pkg;

	// ----------------------------------------
	// Sizes and fixed header layout
	// ----------------------------------------
	localparam int FECRP_COL_MAX = 16; // Columns the payload store can hold
	localparam int FECRP_COL_W = 4; // Column index width
	localparam int FECRP_OFF_W = 11; // Byte offset width inside one column
	localparam int FECRP_ADDR_W = 15; // Column index plus byte offset
	localparam logic [15:0] FECRP_PAY_MAX = 16'h0800; // Stored bytes per column
	localparam logic [11:0] FECRP_PAY_MAX_S = 12'h800; // Same figure, length width
	localparam logic [15:0] FECRP_RTP_HDR_LEN = 16'h000c; // Fixed RTP header bytes
	localparam logic [11:0] FECRP_FEC_HDR_LEN = 12'h010; // FEC header bytes
	localparam logic [11:0] FECRP_REP_HDR_LEN = 12'h01c; // RTP plus FEC header
	localparam logic [11:0] FECRP_REP_LAST_HDR = 12'h01b; // Index of last header byte

	// ----------------------------------------
	// Field values
	// ----------------------------------------
	localparam logic [1:0] FECRP_RTP_VERSION = 2'h2; // Version field value
	localparam logic FECRP_E_FLAG = 1'h1; // Extended FEC header present
	localparam logic FECRP_N_FLAG = 1'h0; // Reserved extension flag
	localparam logic FECRP_D_FLAG = 1'h0; // Unused flag
	localparam logic [2:0] FECRP_CODE_TYPE = 3'h0; // Only code type defined
	localparam logic [2:0] FECRP_INDEX = 3'h0; // Unused index field
	localparam logic [23:0] FECRP_MASK = 24'h000000; // Unused mask field
	localparam logic [7:0] FECRP_BASE_EXT = 8'h00; // Unused base extension
	localparam logic [31:0] FECRP_LFSR_SEED = 32'h1d2c3b4a; // Arbitrary nonzero seed
	localparam logic [31:0] FECRP_LFSR_TAPS = 32'h80200003; // Feedback polynomial

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] data; // One octet of a packet
		logic first; // First octet of the packet
		logic last; // Last octet of the packet
	} fecrp_beat_t;

	typedef struct packed {
		logic [7:0] cols; // Columns of the source block
		logic [7:0] rows; // Rows of the source block
		logic [6:0] pt; // Dynamic payload type of the repair flow
	} fecrp_cfg_t;

	// Running parity of one column
	typedef struct packed {
		logic p;
		logic x;
		logic [3:0] cc;
		logic m;
		logic [6:0] pt;
		logic [31:0] ts;
		logic [15:0] len;
		logic [15:0] base;
		logic [11:0] maxlen;
	} fecrp_col_t;

	typedef enum logic [1:0] {
		FECRP_IDLE = 2'b01,
		FECRP_EMIT = 2'b10
	} fecrp_phase_t;

	typedef struct packed {
		logic ready;
		logic src_valid;
		fecrp_beat_t src_out;
		logic rep_valid;
		fecrp_beat_t rep_out;
		logic [15:0] cnt;
		logic [3:0] col;
		logic [7:0] row;
		logic [7:0] cur_b0;
		logic [7:0] cur_b1;
		logic [15:0] cur_sn;
		logic [31:0] cur_ts;
		fecrp_col_t [FECRP_COL_MAX-1:0] meta;
		fecrp_phase_t phase;
		logic [11:0] emit_idx;
		logic [3:0] emit_col;
		logic id_valid;
		logic [15:0] seq;
		logic [31:0] ssrc;
		logic [31:0] ts;
		logic [31:0] lfsr;
	} fecrp_state_t;

endpackage : fecrp_pkg

/* File: design/fecrp_col_mem.sv */
`timescale 1ns/100ps
module fecrp_col_mem (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [fecrp_pkg::FECRP_ADDR_W-1:0] addr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data
);
	import fecrp_pkg::*;

	// ----------------------------------------
	// Column parity store
	// ----------------------------------------
	// One region per column; no reset, a column is overwritten on its first row
	logic [7:0] mem [0:(1<<FECRP_ADDR_W)-1];

	// Read is combinational so read-modify-write fits one accepted octet
	assign rd_data = mem[addr];

	// Write port
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
	end

endmodule : fecrp_col_mem

/* File: design/fecrp_builder.sv */
`timescale 1ns/100ps
module fecrp_builder (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire fecrp_pkg::fecrp_cfg_t CFG,
	input wire logic [31:0] MEDIA_TIME,
	input wire logic [31:0] ENTROPY,
	input wire logic SRC_IN_VALID,
	input wire fecrp_pkg::fecrp_beat_t SRC_IN,
	output logic SRC_IN_READY,
	output logic SRC_OUT_VALID,
	output fecrp_pkg::fecrp_beat_t SRC_OUT,
	output logic REP_OUT_VALID,
	output fecrp_pkg::fecrp_beat_t REP_OUT
);
	import fecrp_pkg::*;

	// ----------------------------------------
	// Timing at a glance
	// ----------------------------------------
	// An accepted octet is copied to the source output one cycle later.
	// The last octet of a packet in the final row starts a repair:
	// ready drops on the next cycle and the first repair octet follows.
	// A repair is 28 header octets plus the longest stored payload
	// of its column; ready rises together with its last octet.
	// Columns are walked before rows, so the repairs of one block
	// leave in column order, each right after its final-row packet.
	// The source side must tolerate the stall for a whole repair;
	// a buffer would hide it but would cost a second store.
	// Limitation: sequence numbers inside a column are assumed to rise,
	// so the row zero packet supplies the base of the column.
	// Limitation: only the first 2048 protected octets are stored,
	// while the length recovery still folds in the full length.
	// Limitation: a configuration change in mid-block mixes two grids;
	// hold the configuration steady and reset between grids.

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Octet of the 28-octet repair header: RTP header then FEC header
	function automatic logic [7:0] hdr_byte(
		input logic [11:0] idx,
		input fecrp_col_t c,
		input fecrp_cfg_t cfg,
		input logic [15:0] seq,
		input logic [31:0] ts,
		input logic [31:0] ssrc
	);
		logic [7:0] b;
		b = 8'h00;
		case (idx[4:0])
			// Fixed RTP header, never any optional part
			5'h00: b = {FECRP_RTP_VERSION, c.p, c.x, c.cc};
			5'h01: b = {c.m, cfg.pt};
			5'h02: b = seq[15:8];
			5'h03: b = seq[7:0];
			5'h04: b = ts[31:24];
			5'h05: b = ts[23:16];
			5'h06: b = ts[15:8];
			5'h07: b = ts[7:0];
			5'h08: b = ssrc[31:24];
			5'h09: b = ssrc[23:16];
			5'h0a: b = ssrc[15:8];
			5'h0b: b = ssrc[7:0];
			// FEC header proper, sixteen octets
			5'h0c: b = c.base[15:8];
			5'h0d: b = c.base[7:0];
			5'h0e: b = c.len[15:8];
			5'h0f: b = c.len[7:0];
			5'h10: b = {FECRP_E_FLAG, c.pt};
			5'h11: b = FECRP_MASK[23:16];
			5'h12: b = FECRP_MASK[15:8];
			5'h13: b = FECRP_MASK[7:0];
			5'h14: b = c.ts[31:24];
			5'h15: b = c.ts[23:16];
			5'h16: b = c.ts[15:8];
			5'h17: b = c.ts[7:0];
			5'h18: b = {FECRP_N_FLAG, FECRP_D_FLAG, FECRP_CODE_TYPE, FECRP_INDEX};
			5'h19: b = cfg.cols;
			5'h1a: b = cfg.rows;
			5'h1b: b = FECRP_BASE_EXT;
			default: b = 8'h00; // Indices past the header never reach here
		endcase
		return b;
	endfunction : hdr_byte

	// Next value of the free-running random source
	// Left shift with the taps folded in when the top bit leaves;
	// outside entropy keeps the start of the repair flow unpredictable
	function automatic logic [31:0] lfsr_step(input logic [31:0] v, input logic [31:0] mix);
		logic [31:0] r;
		r = {v[30:0], 1'b0};
		if (v[31]) begin
			r = r ^ FECRP_LFSR_TAPS;
		end
		return r ^ mix;
	endfunction : lfsr_step

	// ----------------------------------------
	// State
	// ----------------------------------------
	// One record, so reset and registering stay in one place
	fecrp_state_t s_reg; // All registered state
	fecrp_state_t s_next; // Its next value
	logic mem_we; // Parity store write strobe
	logic [FECRP_ADDR_W-1:0] mem_addr; // Shared store address
	logic [7:0] mem_wdata; // Octet written into the store
	logic [7:0] mem_rdata; // Octet read from the store

	// Temporaries of the combinational process
	logic take; // An input octet is accepted this cycle
	logic [15:0] idx; // Position of the accepted octet in its packet
	logic [15:0] off; // Position inside the protected part
	logic [15:0] plen; // Protected length of the ending packet
	logic [11:0] slen; // Stored length, capped to the store
	logic in_pay; // Accepted octet lies in the protected part and fits
	logic col_end; // Last column of the row
	logic blk_end; // Last row of the block
	fecrp_col_t cm; // Column being accumulated
	fecrp_col_t em; // Column being emitted
	logic [11:0] last_idx; // Index of the final repair octet
	logic [11:0] eoff; // Payload offset of the emitted octet

	// ----------------------------------------
	// Parity store
	// ----------------------------------------
	// Shared by accumulation and emission, never both in one cycle:
	// the input is stalled while a repair goes out
	fecrp_col_mem u_col_mem (
		.clk(CORE_CLK),
		.wr_en(mem_we),
		.addr(mem_addr),
		.wr_data(mem_wdata),
		.rd_data(mem_rdata)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// Input is stalled for the whole emission, so the store and the column
	// records are never touched from both sides in one cycle; the cost is
	// that the source must accept back-pressure for 28 plus payload cycles.
	always_comb begin
		s_next = s_reg;
		mem_we = 1'b0;
		mem_wdata = 8'h00;
		mem_addr = '0;
		take = SRC_IN_VALID && s_reg.ready;
		idx = SRC_IN.first ? 16'h0000 : s_reg.cnt;
		off = idx - FECRP_RTP_HDR_LEN;
		plen = 16'h0000;
		slen = 12'h000;
		in_pay = (idx >= FECRP_RTP_HDR_LEN) && (off < FECRP_PAY_MAX);
		col_end = ({4'h0, s_reg.col} == (CFG.cols - 8'h01)) || (CFG.cols == 8'h00);
		blk_end = (s_reg.row == (CFG.rows - 8'h01)) || (CFG.rows == 8'h00);
		cm = s_reg.meta[s_reg.col];
		em = s_reg.meta[s_reg.emit_col];
		last_idx = FECRP_REP_LAST_HDR + em.maxlen;
		eoff = s_reg.emit_idx - FECRP_REP_HDR_LEN;

		// Random source runs every cycle and folds in outside entropy
		s_next.lfsr = lfsr_step(s_reg.lfsr, ENTROPY);

		// Output pulses last one cycle unless refreshed
		s_next.src_valid = 1'b0;
		s_next.rep_valid = 1'b0;

		// Source pass-through: the octet leaves exactly as it came
		if (take) begin
			s_next.src_valid = 1'b1;
			s_next.src_out = SRC_IN;
		end

		// Accumulation of the source octet into its column
		if (take) begin
			// Position counter; a first flag always restarts it
			s_next.cnt = idx + 16'h0001;
			// Capture fixed RTP header fields of this packet
			unique case (idx)
				16'h0000: s_next.cur_b0 = SRC_IN.data;
				16'h0001: s_next.cur_b1 = SRC_IN.data;
				16'h0002: s_next.cur_sn[15:8] = SRC_IN.data;
				16'h0003: s_next.cur_sn[7:0] = SRC_IN.data;
				16'h0004: s_next.cur_ts[31:24] = SRC_IN.data;
				16'h0005: s_next.cur_ts[23:16] = SRC_IN.data;
				16'h0006: s_next.cur_ts[15:8] = SRC_IN.data;
				16'h0007: s_next.cur_ts[7:0] = SRC_IN.data;
				default: begin
				end
			endcase
			// Everything past the fixed header is protected data
			if (in_pay) begin
				mem_we = 1'b1;
				mem_addr = {s_reg.col, off[FECRP_OFF_W-1:0]};
				// First row writes; later rows XOR inside the longest length so far
				if ((s_reg.row != 8'h00) && (off < {4'h0, cm.maxlen})) begin
					mem_wdata = SRC_IN.data ^ mem_rdata;
				end else begin
					mem_wdata = SRC_IN.data;
				end
			end
			// End of packet: fold header fields into the column record
			if (SRC_IN.last) begin
				// Packets shorter than the fixed header protect nothing
				if (idx >= (FECRP_RTP_HDR_LEN - 16'h0001)) begin
					plen = idx + 16'h0001 - FECRP_RTP_HDR_LEN;
				end
				// Only what fits the store takes part in the payload parity
				slen = (plen > FECRP_PAY_MAX) ? FECRP_PAY_MAX_S : plen[11:0];
				// Row zero starts the column afresh; later rows fold in
				if (s_reg.row == 8'h00) begin
					cm.p = s_next.cur_b0[5];
					cm.x = s_next.cur_b0[4];
					cm.cc = s_next.cur_b0[3:0];
					cm.m = s_next.cur_b1[7];
					cm.pt = s_next.cur_b1[6:0];
					cm.ts = s_next.cur_ts;
					cm.len = plen;
					cm.base = s_next.cur_sn;
					cm.maxlen = slen;
				end else begin
					cm.p = cm.p ^ s_next.cur_b0[5];
					cm.x = cm.x ^ s_next.cur_b0[4];
					cm.cc = cm.cc ^ s_next.cur_b0[3:0];
					cm.m = cm.m ^ s_next.cur_b1[7];
					cm.pt = cm.pt ^ s_next.cur_b1[6:0];
					cm.ts = cm.ts ^ s_next.cur_ts;
					cm.len = cm.len ^ plen;
					if (slen > cm.maxlen) begin
						cm.maxlen = slen;
					end
				end
				// Updated record goes back to its column
				s_next.meta[s_reg.col] = cm;
				// Walk the grid column by column, then row by row
				// Zero columns or rows behave as one
				if (col_end) begin
					s_next.col = 4'h0;
					s_next.row = blk_end ? 8'h00 : (s_reg.row + 8'h01);
				end else begin
					s_next.col = s_reg.col + 4'h1;
				end
				// A column whose last row just ended is sent at once
				if (blk_end) begin
					s_next.phase = FECRP_EMIT;
					s_next.ready = 1'b0;
					s_next.emit_col = s_reg.col;
					s_next.emit_idx = 12'h000;
					s_next.ts = MEDIA_TIME;
					// Identity of the repair flow is drawn once
					// Reset clears the flag, so a new flow draws a new identity
					if (!s_reg.id_valid) begin
						s_next.id_valid = 1'b1;
						s_next.seq = s_reg.lfsr[31:16] ^ s_reg.lfsr[15:0];
						s_next.ssrc = s_reg.lfsr;
					end
				end
			end
		end

		// Repair emission
		// The emitted column stays frozen while its repair goes out
		unique case (s_reg.phase)
			FECRP_IDLE: begin
				// Nothing to send
			end
			FECRP_EMIT: begin
				// One octet per cycle; nothing downstream can stall it
				s_next.rep_valid = 1'b1;
				s_next.rep_out.first = (s_reg.emit_idx == 12'h000);
				s_next.rep_out.last = (s_reg.emit_idx == last_idx);
				if (s_reg.emit_idx < FECRP_REP_HDR_LEN) begin
					// Header of exactly 12 plus 16 octets, no optional parts
					s_next.rep_out.data = hdr_byte(s_reg.emit_idx, em, CFG,
						s_reg.seq, s_reg.ts, s_reg.ssrc);
				end else begin
					// Payload octets come from the column's store region
					mem_addr = {s_reg.emit_col, eoff[FECRP_OFF_W-1:0]};
					s_next.rep_out.data = mem_rdata;
				end
				// Final octet: reopen the input and advance the sequence
				if (s_reg.emit_idx == last_idx) begin
					s_next.phase = FECRP_IDLE;
					s_next.ready = 1'b1;
					s_next.seq = s_reg.seq + 16'h0001;
				end else begin
					s_next.emit_idx = s_reg.emit_idx + 12'h001;
				end
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Seed loaded here; outside entropy stirs it from then on
	// Synchronous reset; the parity store needs no clearing because the
	// first row of each block overwrites it
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			s_reg <= '0;
			s_reg.ready <= 1'b1;
			s_reg.phase <= FECRP_IDLE;
			s_reg.lfsr <= FECRP_LFSR_SEED;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------
	// Plain renames of register fields, no logic in front of the pins
	assign SRC_IN_READY = s_reg.ready;
	assign SRC_OUT_VALID = s_reg.src_valid;
	assign SRC_OUT = s_reg.src_out;
	assign REP_OUT_VALID = s_reg.rep_valid;
	assign REP_OUT = s_reg.rep_out;

endmodule : fecrp_builder

/* File: testbench/fecrp_builder_props.sv */
`timescale 1ns/100ps
// ----------
// Port checks
// ----------
module fecrp_builder_props (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire fecrp_pkg::fecrp_cfg_t CFG,
	input wire logic SRC_IN_VALID,
	input wire fecrp_pkg::fecrp_beat_t SRC_IN,
	input wire logic SRC_IN_READY,
	input wire logic SRC_OUT_VALID,
	input wire fecrp_pkg::fecrp_beat_t SRC_OUT,
	input wire logic REP_OUT_VALID,
	input wire fecrp_pkg::fecrp_beat_t REP_OUT
);
	import fecrp_pkg::*;
	logic [11:0] idx_reg; // Octet index inside a repair
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);
	// Index restarts after each last octet, so header bytes are addressable
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			idx_reg <= 12'h000;
		end else if (REP_OUT_VALID) begin
			idx_reg <= REP_OUT.last ? 12'h000 : idx_reg + 12'h001;
		end
	end
	src_copy_a: assert property (SRC_IN_VALID && SRC_IN_READY |=>
		SRC_OUT_VALID && SRC_OUT == $past(SRC_IN))
		else $error("source octet not copied");
	src_quiet_a: assert property (!(SRC_IN_VALID && SRC_IN_READY) |=> !SRC_OUT_VALID)
		else $error("source valid without input");
	rep_start_a: assert property ($fell(SRC_IN_READY) |=>
		REP_OUT_VALID && REP_OUT.first && REP_OUT.data[7:6] == 2'h2)
		else $error("repair start wrong");
	rep_body_a: assert property (REP_OUT_VALID && REP_OUT.first |->
		(REP_OUT_VALID && !REP_OUT.last && !SRC_IN_READY) [*8])
		else $error("repair too short");
	rep_done_a: assert property (REP_OUT_VALID && REP_OUT.last |=>
		SRC_IN_READY && !REP_OUT_VALID)
		else $error("ready not back after repair");
	rep_pt_a: assert property (REP_OUT_VALID && idx_reg == 12'h001 |->
		REP_OUT.data[6:0] == CFG.pt)
		else $error("repair payload type wrong");
	ext_flag_a: assert property (REP_OUT_VALID && idx_reg == 12'h010 |->
		REP_OUT.data[7])
		else $error("extension flag clear");
	code_type_a: assert property (REP_OUT_VALID && idx_reg == 12'h018 |->
		REP_OUT.data == 8'h00)
		else $error("code type octet wrong");
	grid_cols_a: assert property (REP_OUT_VALID && idx_reg == 12'h019 |->
		REP_OUT.data == CFG.cols ##1 REP_OUT.data == CFG.rows)
		else $error("grid size octets wrong");
	c_rep: cover property ($rose(REP_OUT_VALID));
	c_take: cover property (SRC_IN_VALID && SRC_IN_READY && SRC_IN.last);
	c_end: cover property (REP_OUT_VALID && REP_OUT.last);
endmodule : fecrp_builder_props
bind fecrp_builder fecrp_builder_props u_props (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
	.CFG(CFG), .SRC_IN_VALID(SRC_IN_VALID), .SRC_IN(SRC_IN), .SRC_IN_READY(SRC_IN_READY),
	.SRC_OUT_VALID(SRC_OUT_VALID), .SRC_OUT(SRC_OUT), .REP_OUT_VALID(REP_OUT_VALID),
	.REP_OUT(REP_OUT));

/* File: testbench/fecrp_rx.sv */
`timescale 1ns/100ps
// ----------
// Network receiver model
// ----------
module fecrp_rx (
	input wire logic clk,
	input wire logic src_v,
	input wire fecrp_pkg::fecrp_beat_t src_b,
	input wire logic rep_v,
	input wire fecrp_pkg::fecrp_beat_t rep_b
);
	import fecrp_pkg::*;
	logic [7:0] sq[$]; // Source flow as a legacy receiver sees it
	logic [7:0] rq[$]; // Repair flow octets
	logic [1:0] rf[$]; // First and last flags of each repair octet
	// No back-pressure exists, so every valid cycle must be caught
	always @(posedge clk) begin
		if (src_v === 1'b1) begin
			sq.push_back(src_b.data);
		end
		if (rep_v === 1'b1) begin
			rq.push_back(rep_b.data);
			rf.push_back({rep_b.first, rep_b.last});
		end
	end
endmodule : fecrp_rx

/* File: testbench/tb_fecrp_builder.sv */
`timescale 1ns/100ps
// ----------
// Repair builder bench
// ----------
module tb_fecrp_builder;
	import fecrp_pkg::*;
	logic CORE_CLK = 1'b0;
	logic RST_N = 1'b0;
	fecrp_cfg_t CFG = '0;
	logic [31:0] MEDIA_TIME = 32'h0;
	logic [31:0] ENTROPY = 32'h5a0f3c96; // Fixed noise feed
	logic SRC_IN_VALID = 1'b0;
	fecrp_beat_t SRC_IN = '0;
	logic SRC_IN_READY;
	logic SRC_OUT_VALID;
	logic REP_OUT_VALID;
	fecrp_beat_t SRC_OUT;
	fecrp_beat_t REP_OUT;
	int miscompares = 0;
	int n_checks = 0;
	logic [7:0] sx[$]; // Expected forwarded octets
	logic [7:0] px[2][64]; // Payload parity per column
	logic [7:0] b0x[2]; // First octet parity
	logic [7:0] b1x[2]; // Second octet parity
	logic [31:0] tx[2]; // Timestamp parity
	logic [15:0] lx[2]; // Length parity
	logic [15:0] bs[2]; // Row zero sequence
	int mx[2]; // Longest payload
	fecrp_builder u_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CFG(CFG),
		.MEDIA_TIME(MEDIA_TIME), .ENTROPY(ENTROPY), .SRC_IN_VALID(SRC_IN_VALID),
		.SRC_IN(SRC_IN), .SRC_IN_READY(SRC_IN_READY), .SRC_OUT_VALID(SRC_OUT_VALID),
		.SRC_OUT(SRC_OUT), .REP_OUT_VALID(REP_OUT_VALID), .REP_OUT(REP_OUT));
	fecrp_rx u_rx (.clk(CORE_CLK), .src_v(SRC_OUT_VALID), .src_b(SRC_OUT),
		.rep_v(REP_OUT_VALID), .rep_b(REP_OUT));
	// Free-running clock
	initial begin
		forever #2 CORE_CLK = ~CORE_CLK;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Reset and clear the model; a new block restarts at column zero
	task rst(input fecrp_cfg_t c);
		@(negedge CORE_CLK);
		RST_N = 1'b0;
		CFG = c;
		sx.delete();
		u_rx.rq.delete();
		u_rx.rf.delete();
		u_rx.sq.delete();
		for (int k = 0; k < 2; k++) begin
			px[k] = '{default: 8'h00};
			b0x[k] = 8'h00;
			b1x[k] = 8'h00;
			tx[k] = 32'h0;
			lx[k] = 16'h0;
			mx[k] = 0;
		end
		repeat (3) @(negedge CORE_CLK);
		RST_N = 1'b1;
	endtask : rst
	// One source packet; holds each octet while ready is low
	task send(input int c, input int r, input logic [15:0] sn, input logic [7:0] b0,
		input logic [7:0] b1, input logic [31:0] ts, input int n);
		logic [7:0] pk[$];
		pk = {b0, b1, sn[15:8], sn[7:0], ts[31:24], ts[23:16], ts[15:8], ts[7:0],
			8'h11, 8'h22, 8'h33, 8'h44};
		for (int i = 0; i < n; i++) begin
			pk.push_back(sn[7:0] ^ 8'(i * 37));
			px[c][i] ^= pk[12 + i];
		end
		b0x[c] ^= b0;
		b1x[c] ^= b1;
		tx[c] ^= ts;
		lx[c] ^= 16'(n);
		if (r == 0) bs[c] = sn;
		if (n > mx[c]) mx[c] = n;
		foreach (pk[i]) begin
			@(negedge CORE_CLK);
			SRC_IN_VALID = 1'b1;
			SRC_IN = '{data: pk[i], first: i == 0, last: i == pk.size() - 1};
			while (SRC_IN_READY !== 1'b1) @(negedge CORE_CLK);
			sx.push_back(pk[i]);
			@(posedge CORE_CLK);
		end
		@(negedge CORE_CLK);
		SRC_IN_VALID = 1'b0;
	endtask : send
	// Bounded wait, then a few idle cycles to catch surplus octets
	task wait_rep(input int n);
		for (int k = 0; k < 400 && u_rx.rq.size() < n; k++) @(negedge CORE_CLK);
		repeat (4) @(negedge CORE_CLK);
		chk(u_rx.rq.size(), n);
	endtask : wait_rep
	// Sequence and identity octets are random, so they are skipped here
	task chk_rep(input int c, input int o, input logic [31:0] t);
		logic [7:0] e[$];
		e = {8'h80 | (b0x[c] & 8'h3f), (b1x[c] & 8'h80) | 8'(CFG.pt), 8'h00, 8'h00,
			t[31:24], t[23:16], t[15:8], t[7:0], 8'h00, 8'h00, 8'h00, 8'h00,
			bs[c][15:8], bs[c][7:0], lx[c][15:8], lx[c][7:0], 8'h80 | b1x[c],
			8'h00, 8'h00, 8'h00, tx[c][31:24], tx[c][23:16], tx[c][15:8], tx[c][7:0],
			8'h00, CFG.cols, CFG.rows, 8'h00};
		for (int i = 0; i < mx[c]; i++) e.push_back(px[c][i]);
		foreach (e[i]) begin
			if (i != 2 && i != 3 && (i < 8 || i > 11)) begin
				chk(u_rx.rq[o + i], e[i]);
			end
		end
		// Frame marks: first on the opening octet, last on the final one
		chk(u_rx.rf[o], 2'b10);
		chk(u_rx.rf[o + e.size() - 1], 2'b01);
	endtask : chk_rep
	task chk_src;
		chk(u_rx.sq.size(), sx.size());
		foreach (sx[i]) chk(u_rx.sq[i], sx[i]);
	endtask : chk_src
	// Two by two grid, sequence wrap, empty and uneven payloads
	task t_block;
		logic [15:0] s;
		rst('{cols: 8'h02, rows: 8'h02, pt: 7'h61});
		send(0, 0, 16'hfffe, 8'ha5, 8'h9f, 32'h01020304, 5);
		send(1, 0, 16'hffff, 8'h93, 8'h1f, 32'h11223344, 0);
		MEDIA_TIME = 32'hcafe0001;
		send(0, 1, 16'h0000, 8'hb1, 8'h9f, 32'h55667788, 9);
		repeat (4) @(negedge CORE_CLK);
		MEDIA_TIME = 32'hcafe0002;
		send(1, 1, 16'h0001, 8'h80, 8'h1f, 32'h99aabbcc, 3);
		wait_rep(56 + mx[0] + mx[1]);
		chk_rep(0, 0, 32'hcafe0001);
		chk_rep(1, 28 + mx[0], 32'hcafe0002);
		s = {u_rx.rq[2], u_rx.rq[3]};
		// Cast keeps the wrap from 16'hffff to zero inside sixteen bits
		chk({u_rx.rq[30 + mx[0]], u_rx.rq[31 + mx[0]]}, 16'(s + 16'h0001));
		for (int i = 8; i < 12; i++) chk(u_rx.rq[28 + mx[0] + i], u_rx.rq[i]);
		chk_src();
	endtask : t_block
	// Single cell grid, all header flags set, nothing to protect
	task t_single;
		rst('{cols: 8'h01, rows: 8'h01, pt: 7'h23});
		MEDIA_TIME = 32'h0bad0f00;
		send(0, 0, 16'h1234, 8'hbf, 8'ha3, 32'hdeadbeef, 0);
		wait_rep(28);
		chk_rep(0, 0, 32'h0bad0f00);
		chk_src();
	endtask : t_single
	task wrap_up;
		if (miscompares == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	// Main sequence
	initial begin
		t_block();
		t_single();
		wrap_up();
	end
	// Watchdog; both tests need well under a thousand cycles
	initial begin
		#40000;
		miscompares++;
		wrap_up();
	end
endmodule : tb_fecrp_builder
